// ==== hdl/scps_clock_pwm.sv ====
`timescale 1ns/1ns
`include "scps_map.svh"
// Function
// - pulse generator only, no capture/compare
// - period is (limit+1) times tick times prescale
// - match then wrap to zero, reload duty
// - high time equals duty count ticks
// - duty writes apply only after reload
// - stand-alone output is fixed system clock
// - primary drive only while clock low
// - master drives system clock onto sync pin
// - slave: sync OR local match reloads buffers
// - slave start delayed by phase count
// - sleep freezes prescaler, timer and sync history, pin holds level
// - faults gate drives and set flags
// - run bit and 2-bit prescale select
module scps_clock_pwm (
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 reset_in,
  // avalon-mm slave
  input  wire logic [4:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [3:0]           avs_byteenable_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  // device state and comparators
  input  wire logic                 sleep_in,
  input  wire scps_pkg::scps_fault_t fault_in,
  // gate drive requests from the analog loop
  input  wire logic                 primary_request_in,
  input  wire logic                 secondary_request_in,
  // sync pin, two-way
  input  wire logic                 sync_clock_pin_in,
  output logic                      sync_clock_pin_out,
  output logic                      sync_clock_pin_oe_out,
  // outputs
  output logic                      clock_output_pin_out,
  output logic                      primary_gate_drive_out,
  output logic                      secondary_gate_drive_out,
  output logic                      irq_out
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [2:0]              sync_mode_control;
  logic                    timer_run_bit;
  logic [1:0]              timer_prescale_select;
  logic [7:0]              period_limit;
  logic [7:0]              duty_buffer;
  logic [7:0]              phase_shift_buffer;
  logic [`SCPS_ST_W-1:0]   irq_status;
  logic [`SCPS_ST_W-1:0]   irq_mask;
  logic [7:0]              period_timer_count;
  logic [7:0]              active_duty;
  logic [7:0]              active_phase_shift;
  logic [7:0]              phase_left;
  logic [3:0]              presc_count;
  logic                    clk_q;
  logic                    sync_q;
  scps_pkg::scps_fault_t   fault_q;
  scps_pkg::scps_bus_t     bus_state;
  scps_pkg::scps_mode_t    mode;
  logic                    active;
  logic                    tick;
  logic                    local_match;
  logic                    sync_rise;
  logic                    slave_reload;
  logic                    reload;
  logic                    wr_en;
  logic                    fault_any;
  logic [`SCPS_ST_W-1:0]   irq_event;
  logic [7:0]              next_count;
  logic [7:0]              next_phase;
  logic [7:0]              next_duty;
  logic                    next_clk;

  // prescale terminal count for a select code
  function automatic logic [3:0] ps_term(input logic [1:0] sel);
    unique case (sel)
      2'h0: ps_term = `SCPS_PS_DIV1;
      2'h1: ps_term = `SCPS_PS_DIV4;
      2'h2: ps_term = `SCPS_PS_DIV8;
      2'h3: ps_term = `SCPS_PS_DIV16;
    endcase
  endfunction

  // mode field decode, unknown codes act as stand-alone
  function automatic scps_pkg::scps_mode_t mode_of(input logic [2:0] code);
    if (code == `SCPS_CODE_MASTER) begin
      mode_of = scps_pkg::SCPS_MASTER;
    end else if (code == `SCPS_CODE_SLAVE) begin
      mode_of = scps_pkg::SCPS_SLAVE;
    end else begin
      mode_of = scps_pkg::SCPS_ALONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // timebase, no capture or compare path exists here
  // ----------------------------------------------------------------
  assign mode         = mode_of(sync_mode_control);
  assign active       = timer_run_bit & ~sleep_in;
  assign tick         = active & (presc_count == ps_term(timer_prescale_select));
  assign local_match  = tick & (phase_left == `SCPS_RST_BYTE) & (period_timer_count == period_limit);
  assign sync_rise    = sync_clock_pin_in & ~sync_q;
  assign slave_reload = active & (mode == scps_pkg::SCPS_SLAVE) & sync_rise;
  assign reload       = local_match | slave_reload;

  // prescaler, frozen when stopped or asleep
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      presc_count <= 4'h0;
    end else if (tick) begin
      presc_count <= 4'h0;
    end else if (active) begin
      presc_count <= presc_count + 4'h1;
    end
  end

  // next values of the period timer and clock level
  always_comb begin
    next_count = period_timer_count;
    next_phase = phase_left;
    next_duty  = reload ? duty_buffer : active_duty;
    if (slave_reload) begin
      next_count = `SCPS_RST_BYTE;
      next_phase = phase_shift_buffer;
    end else if (tick) begin
      if (phase_left != `SCPS_RST_BYTE) begin
        next_phase = phase_left - 8'h01;
      end else if (local_match) begin
        next_count = `SCPS_RST_BYTE;
      end else begin
        next_count = period_timer_count + 8'h01;
      end
    end
    next_clk = (next_phase == `SCPS_RST_BYTE) & (next_count < next_duty);
  end

  // timer, active buffers and clock level
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      period_timer_count <= `SCPS_RST_BYTE;
      phase_left         <= `SCPS_RST_BYTE;
      active_duty        <= `SCPS_RST_BYTE;
      active_phase_shift <= `SCPS_RST_BYTE;
      clk_q              <= 1'b0;
    end else if (tick | slave_reload) begin
      period_timer_count <= next_count;
      phase_left         <= next_phase;
      active_duty        <= next_duty;
      clk_q              <= next_clk;
      if (reload) begin
        active_phase_shift <= phase_shift_buffer;
      end
    end
  end

  // sync pin edge history, idles high like the pulled-up pin, held during sleep
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sync_q <= 1'b1;
    end else if (!sleep_in) begin
      sync_q <= sync_clock_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // pins and gate drives
  // ----------------------------------------------------------------
  assign fault_any                = |fault_in;
  assign clock_output_pin_out     = clk_q;
  assign sync_clock_pin_out       = clk_q;
  assign sync_clock_pin_oe_out    = (mode == scps_pkg::SCPS_MASTER);
  assign primary_gate_drive_out   = primary_request_in & ~clk_q & ~fault_any;
  assign secondary_gate_drive_out = secondary_request_in & ~fault_any;

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_event = {local_match, fault_in.desat & ~fault_q.desat,
                      fault_in.ov & ~fault_q.ov, fault_in.uv & ~fault_q.uv};
  assign irq_out   = |(irq_status & irq_mask);

  // fault edge history
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      fault_q <= '0;
    end else begin
      fault_q <= fault_in;
    end
  end

  // sticky flags, set wins over write-one clear
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      irq_status <= '0;
    end else if (wr_en && avs_address_in == `SCPS_ADDR_STATUS) begin
      irq_status <= (irq_status & ~avs_writedata_in[`SCPS_ST_W-1:0]) | irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & (bus_state == scps_pkg::SCPS_BUS_IDLE);
  assign wr_en = avs_write_in & (bus_state == scps_pkg::SCPS_BUS_ACK) & avs_byteenable_in[0];

  // access state
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_state <= scps_pkg::SCPS_BUS_IDLE;
    end else if (bus_state == scps_pkg::SCPS_BUS_ACK) begin
      bus_state <= scps_pkg::SCPS_BUS_IDLE;
    end else if (avs_read_in | avs_write_in) begin
      bus_state <= scps_pkg::SCPS_BUS_ACK;
    end
  end

  // read data, unmapped reads return zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && bus_state == scps_pkg::SCPS_BUS_IDLE) begin
      avs_readdata_out <= 32'h0;
      unique case (avs_address_in)
        `SCPS_ADDR_MODE: begin
          avs_readdata_out[`SCPS_MODE_B2] <= sync_mode_control[2];
          avs_readdata_out[`SCPS_MODE_B1] <= sync_mode_control[1];
          avs_readdata_out[`SCPS_MODE_B0] <= sync_mode_control[0];
        end
        `SCPS_ADDR_TCTL: begin
          avs_readdata_out[`SCPS_TCTL_RUN] <= timer_run_bit;
          avs_readdata_out[`SCPS_TCTL_PS_HI:`SCPS_TCTL_PS_LO] <= timer_prescale_select;
        end
        `SCPS_ADDR_PERIOD: avs_readdata_out[7:0] <= period_limit;
        `SCPS_ADDR_DUTY:   avs_readdata_out[7:0] <= duty_buffer;
        `SCPS_ADDR_PHASE:  avs_readdata_out[7:0] <= phase_shift_buffer;
        `SCPS_ADDR_STATUS: avs_readdata_out[`SCPS_ST_W-1:0] <= irq_status;
        `SCPS_ADDR_MASK:   avs_readdata_out[`SCPS_ST_W-1:0] <= irq_mask;
        `SCPS_ADDR_COUNT:  avs_readdata_out[7:0] <= period_timer_count;
        default:           avs_readdata_out <= 32'h0;
      endcase
    end
  end

  // writable registers, buffers accepted at any moment
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      sync_mode_control     <= `SCPS_CODE_ALONE;
      timer_run_bit         <= 1'b0;
      timer_prescale_select <= 2'h0;
      period_limit          <= `SCPS_RST_PERIOD;
      duty_buffer           <= `SCPS_RST_BYTE;
      phase_shift_buffer    <= `SCPS_RST_BYTE;
      irq_mask              <= '0;
    end else if (wr_en) begin
      unique case (avs_address_in)
        `SCPS_ADDR_MODE: begin
          sync_mode_control <= {avs_writedata_in[`SCPS_MODE_B2], avs_writedata_in[`SCPS_MODE_B1],
                                avs_writedata_in[`SCPS_MODE_B0]};
        end
        `SCPS_ADDR_TCTL: begin
          timer_run_bit         <= avs_writedata_in[`SCPS_TCTL_RUN];
          timer_prescale_select <= avs_writedata_in[`SCPS_TCTL_PS_HI:`SCPS_TCTL_PS_LO];
        end
        `SCPS_ADDR_PERIOD: period_limit       <= avs_writedata_in[7:0];
        `SCPS_ADDR_DUTY:   duty_buffer        <= avs_writedata_in[7:0];
        `SCPS_ADDR_PHASE:  phase_shift_buffer <= avs_writedata_in[7:0];
        `SCPS_ADDR_MASK:   irq_mask           <= avs_writedata_in[`SCPS_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_wrap;
    tick && phase_left == 8'h00 && period_timer_count == period_limit;
  endsequence
  sequence s_slave_edge;
    active && mode == scps_pkg::SCPS_SLAVE && sync_clock_pin_in && !sync_q;
  endsequence

  property p_wrap;
    s_wrap |=> period_timer_count == 8'h00 && active_duty == $past(duty_buffer);
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap or reload at period match");

  property p_duty_hold;
    $changed(active_duty) |-> $past(reload);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("active duty changed mid period");

  property p_sleep;
    sleep_in |=> $stable(period_timer_count) && $stable(clk_q) && $stable(presc_count);
  endproperty
  a_sleep: assert property (p_sleep) else $error("state moved during sleep");

  property p_stop;
    !timer_run_bit |=> $stable(period_timer_count);
  endproperty
  a_stop: assert property (p_stop) else $error("timer moved while stopped");

  property p_master_pin;
    mode == scps_pkg::SCPS_MASTER |-> sync_clock_pin_oe_out && sync_clock_pin_out == clock_output_pin_out;
  endproperty
  a_master_pin: assert property (p_master_pin) else $error("master not driving sync pin");

  property p_drive_limit;
    primary_gate_drive_out |-> !clock_output_pin_out;
  endproperty
  a_drive_limit: assert property (p_drive_limit) else $error("primary drive during clock high");

  property p_fault_gate;
    fault_in.uv && !fault_q.uv |-> !primary_gate_drive_out && !secondary_gate_drive_out ##1 irq_status[0];
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault not gated or flagged");

  property p_slave_load;
    s_slave_edge |=> active_phase_shift == $past(phase_shift_buffer) && period_timer_count == 8'h00;
  endproperty
  a_slave_load: assert property (p_slave_load) else $error("slave edge did not reload");

  property p_phase_wait;
    s_slave_edge and phase_shift_buffer != 8'h00 |=> !clock_output_pin_out;
  endproperty
  a_phase_wait: assert property (p_phase_wait) else $error("slave started before phase delay");

  property p_start_high;
    s_wrap and (duty_buffer != 8'h00 && !slave_reload) |=> clock_output_pin_out;
  endproperty
  a_start_high: assert property (p_start_high) else $error("clock not high at period start");

  property p_bus_answer;
    (avs_read_in || avs_write_in) && bus_state == scps_pkg::SCPS_BUS_IDLE |->
      avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not after one wait");

endmodule

// ==== shared/scps_map.svh ====
`ifndef SCPS_MAP_SVH
`define SCPS_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SCPS_ADDR_MODE     5'h00
`define SCPS_ADDR_TCTL     5'h04
`define SCPS_ADDR_PERIOD   5'h08
`define SCPS_ADDR_DUTY     5'h0c
`define SCPS_ADDR_PHASE    5'h10
`define SCPS_ADDR_STATUS   5'h14
`define SCPS_ADDR_MASK     5'h18
`define SCPS_ADDR_COUNT    5'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCPS_MODE_B1       7
`define SCPS_MODE_B0       6
`define SCPS_MODE_B2       3
`define SCPS_TCTL_RUN      2
`define SCPS_TCTL_PS_HI    1
`define SCPS_TCTL_PS_LO    0
`define SCPS_ST_UV         0
`define SCPS_ST_OV         1
`define SCPS_ST_DESAT      2
`define SCPS_ST_MATCH      3
`define SCPS_ST_W          4

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define SCPS_RST_PERIOD    8'hff
`define SCPS_RST_BYTE      8'h00
`define SCPS_PS_DIV1       4'h0
`define SCPS_PS_DIV4       4'h3
`define SCPS_PS_DIV8       4'h7
`define SCPS_PS_DIV16      4'hf
`define SCPS_CODE_ALONE    3'h0
`define SCPS_CODE_MASTER   3'h1
`define SCPS_CODE_SLAVE    3'h2

`endif

// ==== shared/scps_pkg.sv ====
package scps_pkg;

  // sync behaviour selected by the mode field
  typedef enum logic [1:0] {
    SCPS_ALONE  = 2'h0,
    SCPS_MASTER = 2'h1,
    SCPS_SLAVE  = 2'h3
  } scps_mode_t;

  // bus slave answer state
  typedef enum logic {
    SCPS_BUS_IDLE = 1'h0,
    SCPS_BUS_ACK  = 1'h1
  } scps_bus_t;

  // comparator fault levels
  typedef struct packed {
    logic desat;
    logic ov;
    logic uv;
  } scps_fault_t;

endpackage

// ==== test/scps_sync_peer.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// peer converter acting as sync master
// ----------------------------------------------------------------
module scps_sync_peer (
  // clock and control
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  input  wire logic       enable_in,
  input  wire logic [7:0] period_in,
  // sync pin
  output logic            sync_out,
  output logic            sync_oe_out
);
  logic [7:0] count;

  // free running period counter, parked while disabled
  always_ff @(posedge mclk_in) begin
    if (reset_in || !enable_in) begin
      count <= 8'h00;
    end else begin
      count <= (count == period_in - 8'h01) ? 8'h00 : count + 8'h01;
    end
  end

  // master clock high for the first quarter of each period
  assign sync_out    = enable_in && (count < {2'h0, period_in[7:2]});
  assign sync_oe_out = enable_in;
endmodule

// ==== test/test_scps_clock_pwm.sv ====
`timescale 1ns/1ns
`include "scps_map.svh"
// ----------------------------------------------------------------
// bench for the system clock pwm block
// ----------------------------------------------------------------
module test_scps_clock_pwm;
  logic                  mclk_in, reset_in, rd, wr, wait_req, sleep;
  logic [4:0]            addr;
  logic [31:0]           wdata, rdata, q, q2;
  scps_pkg::scps_fault_t fault;
  logic                  prim_req, sec_req, sync_wire, dut_sync, dut_oe;
  logic                  peer_sync, peer_oe, peer_en, clk_pin, p_drv, s_drv, irq;
  int                    err_count = 0;
  int                    checked = 0;
  int                    t0, t1, t2, ts;

  // released sync line reads high through its pull-up
  assign sync_wire = dut_oe ? dut_sync : (peer_oe ? peer_sync : 1'b1);

  scps_clock_pwm u_dut (
    .mclk_in(mclk_in), .reset_in(reset_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(4'h1), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .sleep_in(sleep),
    .fault_in(fault), .primary_request_in(prim_req), .secondary_request_in(sec_req),
    .sync_clock_pin_in(sync_wire), .sync_clock_pin_out(dut_sync),
    .sync_clock_pin_oe_out(dut_oe), .clock_output_pin_out(clk_pin),
    .primary_gate_drive_out(p_drv), .secondary_gate_drive_out(s_drv), .irq_out(irq)
  );
  scps_sync_peer u_peer (
    .mclk_in(mclk_in), .reset_in(reset_in), .enable_in(peer_en), .period_in(8'h18),
    .sync_out(peer_sync), .sync_oe_out(peer_oe)
  );

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked = checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // one avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    addr  <= a;
    wdata <= {24'h0, d};
    wr    <= w;
    rd    <= !w;
    do begin
      @(posedge mclk_in);
      n = n + 1;
    end while (wait_req !== 1'b0 && n < 64);
    if (n >= 64) err_count = err_count + 1;
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_in);
  endtask

  // wait for a level on the clock pin or the sync line, bounded
  task automatic wait_lvl(input logic on_sync, input logic v, output int t);
    int n;
    n = 0;
    do begin
      @(posedge mclk_in);
      n = n + 1;
    end while ((on_sync ? sync_wire : clk_pin) !== v && n < 4000);
    if (n >= 4000) err_count = err_count + 1;
    t = int'($time / 8);
  endtask

  task automatic rise();
    wait_lvl(1'b0, 1'b0, t0);
    wait_lvl(1'b0, 1'b1, t0);
  endtask

  task automatic cycle_times();
    rise();
    wait_lvl(1'b0, 1'b0, t1);
    wait_lvl(1'b0, 1'b1, t2);
  endtask

  // period reset value, prescale table, buffered duty
  task automatic t_period();
    int divs[4] = '{1, 4, 8, 16};
    bus(1'b0, `SCPS_ADDR_PERIOD, 8'h00);
    check(q, 32'hff, "period reset");
    bus(1'b1, 5'h02, 8'h5a);
    bus(1'b0, 5'h02, 8'h00);
    check(q, 32'h0, "unmapped read");
    bus(1'b1, `SCPS_ADDR_PERIOD, 8'h03);
    bus(1'b1, `SCPS_ADDR_DUTY, 8'h02);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `SCPS_ADDR_TCTL, 8'(4 + i));
      cycle_times();
      check(32'(t2 - t0), 32'(4 * divs[i]), "period");
      check(32'(t1 - t0), 32'(2 * divs[i]), "high time");
    end
    rise();
    bus(1'b1, `SCPS_ADDR_DUTY, 8'h01);
    wait_lvl(1'b0, 1'b0, t1);
    check(32'(t1 - t0), 32'h20, "duty held mid period");
    cycle_times();
    check(32'(t1 - t0), 32'h10, "duty after reload");
    $display("test period done");
  endtask

  // sleep while the clock is high
  task automatic t_sleep();
    rise();
    sleep <= 1'b1;
    repeat (20) begin
      @(posedge mclk_in);
      check(32'(clk_pin), 32'h1, "pin holds in sleep");
    end
    bus(1'b0, `SCPS_ADDR_COUNT, 8'h00);
    q2 = q;
    bus(1'b0, `SCPS_ADDR_COUNT, 8'h00);
    check(q, q2, "count frozen");
    ts = int'($time / 8);
    sleep <= 1'b0;
    wait_lvl(1'b0, 1'b0, t1);
    check(32'(t1 - t0), 32'(16 + ts - t0), "resume from frozen state");
    $display("test sleep done");
  endtask

  // master drives the pin, slave follows the peer with a phase offset
  task automatic t_sync();
    int d[2];
    bus(1'b1, `SCPS_ADDR_MODE, 8'h40);
    repeat (40) begin
      @(posedge mclk_in);
      check(32'({dut_oe, dut_sync}), 32'({1'b1, clk_pin}), "master drives pin");
    end
    bus(1'b1, `SCPS_ADDR_PERIOD, 8'h1f);
    bus(1'b1, `SCPS_ADDR_DUTY, 8'h04);
    bus(1'b1, `SCPS_ADDR_TCTL, 8'h04);
    bus(1'b1, `SCPS_ADDR_MODE, 8'h80);
    check(32'(dut_oe), 32'h0, "slave releases pin");
    peer_en <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `SCPS_ADDR_PHASE, 8'(6 * i));
      repeat (3) begin
        wait_lvl(1'b1, 1'b0, t0);
        wait_lvl(1'b1, 1'b1, t0);
      end
      wait_lvl(1'b0, 1'b1, t1);
      d[i] = t1 - t0;
    end
    check(32'(d[1] - d[0]), 32'h6, "phase delay");
    cycle_times();
    check(32'(t2 - t0), 32'h18, "sync sets period");
    check(32'(t1 - t0), 32'h4, "duty from sync reload");
    peer_en <= 1'b0;
    bus(1'b1, `SCPS_ADDR_MODE, 8'hc8);
    bus(1'b0, `SCPS_ADDR_MODE, 8'h00);
    check(q, 32'hc8, "mode field readback");
    check(32'(dut_oe), 32'h0, "unused code acts stand-alone");
    bus(1'b1, `SCPS_ADDR_MODE, 8'h00);
    $display("test sync done");
  endtask

  // drive gating, fault flags, mask and interrupt
  task automatic t_fault();
    prim_req <= 1'b1;
    sec_req  <= 1'b1;
    repeat (70) begin
      @(posedge mclk_in);
      check(32'({p_drv, s_drv}), 32'({!clk_pin, 1'b1}), "primary only while clock low");
    end
    bus(1'b1, `SCPS_ADDR_MASK, 8'h07);
    for (int i = 0; i < 3; i++) begin
      fault <= 3'(1 << i);
      repeat (2) @(posedge mclk_in);
      check(32'({p_drv, s_drv}), 32'h0, "fault gates drives");
      bus(1'b0, `SCPS_ADDR_STATUS, 8'h00);
      check(q & 32'hf, 32'(8 + (1 << i)), "fault and match flags");
      check(32'(irq), 32'h1, "irq raised");
      fault <= 3'h0;
      bus(1'b1, `SCPS_ADDR_STATUS, 8'(1 << i));
      check(32'(irq), 32'h0, "irq cleared");
    end
    $display("test fault done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // clock at 125 MHz
  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  // reset then the scenarios in order
  initial begin
    {reset_in, rd, wr, sleep, prim_req, sec_req, peer_en} = 7'h40;
    addr  = 5'h00;
    wdata = 32'h0;
    fault = 3'h0;
    repeat (16) @(posedge mclk_in);
    reset_in <= 1'b0;
    @(posedge mclk_in);
    t_period();
    t_sleep();
    t_sync();
    t_fault();
    end_of_test();
  end

  // hang guard
  initial begin
    #400000;
    err_count = err_count + 1;
    end_of_test();
  end
endmodule
